//--- adc_pkg.sv
// constants, types and helpers shared by the converter control block
// assumes a single 25 MHz clock and a 32-bit AXI4-Lite register bus
package adc_pkg;
   localparam int ADDR_W = 12;
   localparam int IDX_W = 10;
   typedef logic [7:0] byte_t;
   typedef logic [9:0] sample_t;
   typedef logic [2:0] sel3_t;
   typedef logic [IDX_W-1:0] reg_index_t;
   typedef logic [ADDR_W-1:0] addr_t;

   // register indices; byte address is four times the index
   localparam reg_index_t IDX_CTRL = 10'h093;
   localparam reg_index_t IDX_TIMING = 10'h094;
   localparam reg_index_t IDX_PINSEL = 10'h095;
   localparam reg_index_t IDX_RES_LO = 10'h096;
   localparam reg_index_t IDX_RES_HI = 10'h097;

   localparam int CTRL_EN_BIT = 7;
   localparam int CTRL_FLAG_BIT = 6;
   localparam int CTRL_CMP_BIT = 5;
   localparam int CTRL_SEL_LSB = 1;
   localparam int CTRL_GO_BIT = 0;
   localparam byte_t CTRL_FIXED_MASK = 8'h10;
   localparam byte_t CTRL_RESET = 8'h10;
   localparam int TIMING_DIV_LSB = 5;
   localparam int TIMING_SAMPLE_LSB = 0;
   localparam byte_t TIMING_WMASK = 8'hef;
   localparam byte_t TIMING_RESET = 8'h00;
   localparam byte_t PINSEL_RESET = 8'h00;
   localparam byte_t RES_RESET = 8'h00;

   localparam int DIV_W = 6;
   localparam logic [3:0] SAMPLE_MIN = 4'h2;
   localparam logic [3:0] SAMPLE_MAX = 4'hf;
   localparam logic [3:0] CONVERT_TADS = 4'hc;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} seq_state_t;

   function automatic logic [DIV_W-1:0] tad_div(input sel3_t s);
      case (s)
         3'h0: tad_div = 6'h02;
         3'h1: tad_div = 6'h04;
         3'h2: tad_div = 6'h06;
         3'h3: tad_div = 6'h08;
         3'h4: tad_div = 6'h0c;
         3'h5: tad_div = 6'h10;
         3'h6: tad_div = 6'h18;
         default: tad_div = 6'h20;
      endcase
   endfunction : tad_div

   function automatic logic [3:0] sample_len(input logic [3:0] field);
      if (field == SAMPLE_MAX)
         sample_len = SAMPLE_MAX;
      else if (field + 4'h1 < SAMPLE_MIN)
         sample_len = SAMPLE_MIN;
      else
         sample_len = field + 4'h1;
   endfunction : sample_len

   function automatic logic idx_mapped(input reg_index_t i);
      idx_mapped = (i >= IDX_CTRL) && (i <= IDX_RES_HI);
   endfunction : idx_mapped
endpackage : adc_pkg

//--- tad_divider.sv
// conversion clock divider: one tick per programmed period
// assumes select is held steady while a sequence runs
`timescale 1ns/1ps
module tad_divider (
   input logic aclk,
   input logic aresetn,
   input logic restart,
   input adc_pkg::sel3_t sel,
   output logic tick
);
   import adc_pkg::*;

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
   } div_state_t;

   div_state_t r, n;

   assign tick = (r.cnt == tad_div(sel) - 6'h01);

   always_comb begin
      n = r;
      if (restart || tick)
         n.cnt = '0;
      else
         n.cnt = r.cnt + 6'h01;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         r <= '0;
      else
         r <= n;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   tick_spacing_a: assert property (tick |=> !tick)
      else $error("conversion clock ticks back to back");
   restart_gap_a: assert property (restart |-> ##1 !tick)
      else $error("tick right after restart");
endmodule : tad_divider

//--- axi_lite_regport.sv
// axi4-lite slave front end for byte-wide registers at word addresses
// assumes one write and one read in flight at most
`timescale 1ns/1ps
module axi_lite_regport (
   input logic aclk,
   input logic aresetn,
   input adc_pkg::addr_t awaddr,
   input logic awvalid,
   output logic awready,
   input logic [31:0] wdata,
   input logic [3:0] wstrb,
   input logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input logic bready,
   input adc_pkg::addr_t araddr,
   input logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input logic rready,
   output logic wr_en,
   output adc_pkg::reg_index_t wr_idx,
   output adc_pkg::byte_t wr_data,
   output adc_pkg::reg_index_t rd_idx,
   input adc_pkg::byte_t rd_data
);
   import adc_pkg::*;

   typedef struct packed {
      logic aw_held;
      logic w_held;
      reg_index_t idx;
      byte_t data;
      logic lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } port_state_t;

   port_state_t r, n;
   logic wr_fire;

   assign awready = !r.aw_held && !r.bvalid;
   assign wready = !r.w_held && !r.bvalid;
   assign arready = !r.rvalid;
   assign wr_fire = r.aw_held && r.w_held;
   assign wr_en = wr_fire && idx_mapped(r.idx) && r.lane0;
   assign wr_idx = r.idx;
   assign wr_data = r.data;
   assign rd_idx = araddr[ADDR_W-1:2];
   assign bvalid = r.bvalid;
   assign bresp = r.bresp;
   assign rvalid = r.rvalid;
   assign rdata = r.rdata;
   assign rresp = r.rresp;

   always_comb begin
      n = r;
      if (awvalid && awready) begin
         n.aw_held = 1'b1;
         n.idx = awaddr[ADDR_W-1:2];
      end
      if (wvalid && wready) begin
         n.w_held = 1'b1;
         n.data = wdata[7:0];
         n.lane0 = wstrb[0];
      end
      if (wr_fire) begin
         n.aw_held = 1'b0;
         n.w_held = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = idx_mapped(r.idx) ? RESP_OKAY : RESP_SLVERR;
      end
      if (r.bvalid && bready)
         n.bvalid = 1'b0;
      if (arvalid && arready) begin
         n.rvalid = 1'b1;
         n.rdata = {24'h000000, rd_data};
         n.rresp = idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      end
      if (r.rvalid && rready)
         n.rvalid = 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         r <= '0;
      else
         r <= n;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped before bready");
   rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data changed before rready");
endmodule : axi_lite_regport

//--- adc_control.sv
// sar converter control: registers, start/done sequence, compare mode
// assumes the converter core presents its 10-bit code on core_result
// by the last conversion clock tick of a conversion
`timescale 1ns/1ps
module adc_control (
   input logic aclk,
   input logic aresetn,
   input adc_pkg::addr_t awaddr,
   input logic awvalid,
   output logic awready,
   input logic [31:0] wdata,
   input logic [3:0] wstrb,
   input logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input logic bready,
   input adc_pkg::addr_t araddr,
   input logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input logic rready,
   input logic int_enable,
   output logic conv_int_req,
   output adc_pkg::byte_t pin_route_bits,
   output adc_pkg::sel3_t input_selector,
   output logic sample_hold,
   output logic convert_run,
   output logic conv_clk_tick,
   input adc_pkg::sample_t core_result
);
   import adc_pkg::*;

   typedef struct packed {
      seq_state_t st;
      byte_t ctrl;
      byte_t timing;
      byte_t pinsel;
      logic [1:0] res_lo;
      byte_t res_hi;
      logic [3:0] cnt;
   } ctl_state_t;

   ctl_state_t r, n;
   logic wr_en;
   reg_index_t wr_idx;
   byte_t wr_data;
   reg_index_t rd_idx;
   byte_t rd_data;
   logic tick;
   logic ctrl_wr;
   logic start;
   logic abort;
   logic done;
   logic cmp_mode;
   logic hit;
   logic res_wr;
   sample_t threshold;

   axi_lite_regport u_port (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .wr_en(wr_en),
      .wr_idx(wr_idx),
      .wr_data(wr_data),
      .rd_idx(rd_idx),
      .rd_data(rd_data)
   );

   tad_divider u_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .restart(start),
      .sel(r.timing[TIMING_DIV_LSB +: 3]),
      .tick(tick)
   );

   assign ctrl_wr = wr_en && (wr_idx == IDX_CTRL);
   assign res_wr = wr_en && ((wr_idx == IDX_RES_LO) || (wr_idx == IDX_RES_HI));
   // a start needs the enable, taken from the value being written
   assign start = ctrl_wr && wr_data[CTRL_GO_BIT] && wr_data[CTRL_EN_BIT] && (r.st == ST_IDLE);
   // clearing go or the enable stops a running sequence
   assign abort = ctrl_wr && (r.st != ST_IDLE) && (!wr_data[CTRL_GO_BIT] || !wr_data[CTRL_EN_BIT]);
   assign done = (r.st == ST_CONVERT) && tick && (r.cnt == 4'h1) && !abort;
   assign cmp_mode = r.ctrl[CTRL_CMP_BIT];
   assign threshold = {r.res_hi, r.res_lo};
   assign hit = core_result > threshold;

   always_comb begin
      n = r;
      // software writes first, hardware events below take priority
      if (ctrl_wr) begin
         n.ctrl = (wr_data & ~CTRL_FIXED_MASK) | CTRL_FIXED_MASK;
         if (!wr_data[CTRL_EN_BIT])
            n.ctrl[CTRL_GO_BIT] = 1'b0;
         if (r.st == ST_IDLE && !start)
            n.ctrl[CTRL_GO_BIT] = 1'b0;
      end
      if (wr_en && wr_idx == IDX_TIMING)
         n.timing = wr_data & TIMING_WMASK;
      if (wr_en && wr_idx == IDX_PINSEL)
         n.pinsel = wr_data;
      if (wr_en && wr_idx == IDX_RES_LO)
         n.res_lo = wr_data[1:0];
      if (wr_en && wr_idx == IDX_RES_HI)
         n.res_hi = wr_data;
      case (r.st)
         ST_IDLE: begin
            if (start) begin
               n.st = ST_SAMPLE;
               n.cnt = sample_len(r.timing[TIMING_SAMPLE_LSB +: 4]);
            end
         end
         ST_SAMPLE: begin
            if (abort)
               n.st = ST_IDLE;
            else if (tick && r.cnt == 4'h1) begin
               n.st = ST_CONVERT;
               n.cnt = CONVERT_TADS;
            end else if (tick)
               n.cnt = r.cnt - 4'h1;
         end
         ST_CONVERT: begin
            if (abort)
               n.st = ST_IDLE;
            else if (done && cmp_mode) begin
               // keep comparing until software clears go
               n.st = ST_SAMPLE;
               n.cnt = sample_len(r.timing[TIMING_SAMPLE_LSB +: 4]);
               if (hit)
                  n.ctrl[CTRL_FLAG_BIT] = 1'b1;
            end else if (done) begin
               n.st = ST_IDLE;
               n.res_hi = core_result[9:2];
               n.res_lo = core_result[1:0];
               n.ctrl[CTRL_GO_BIT] = 1'b0;
               n.ctrl[CTRL_FLAG_BIT] = 1'b1;
            end else if (tick)
               n.cnt = r.cnt - 4'h1;
         end
         default: n.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r.st <= ST_IDLE;
         r.ctrl <= CTRL_RESET;
         r.timing <= TIMING_RESET;
         r.pinsel <= PINSEL_RESET;
         r.res_lo <= RES_RESET[1:0];
         r.res_hi <= RES_RESET;
         r.cnt <= 4'h0;
      end else
         r <= n;
   end

   always_comb begin
      case (rd_idx)
         IDX_CTRL: rd_data = r.ctrl;
         IDX_TIMING: rd_data = r.timing;
         IDX_PINSEL: rd_data = r.pinsel;
         IDX_RES_LO: rd_data = {6'h00, r.res_lo};
         IDX_RES_HI: rd_data = r.res_hi;
         default: rd_data = 8'h00;
      endcase
   end

   assign conv_int_req = r.ctrl[CTRL_FLAG_BIT] && int_enable;
   assign pin_route_bits = r.pinsel;
   assign input_selector = r.ctrl[CTRL_SEL_LSB +: 3];
   assign sample_hold = (r.st == ST_SAMPLE);
   assign convert_run = (r.st == ST_CONVERT);
   assign conv_clk_tick = tick && (r.st != ST_IDLE);

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   pin_route_a: assert property (wr_en && wr_idx == IDX_PINSEL |=> pin_route_bits == $past(wr_data))
      else $error("pin routing did not follow the write");
   result_split_a: assert property (done && !cmp_mode |=>
      r.res_hi == $past(core_result[9:2]) && r.res_lo == $past(core_result[1:0]))
      else $error("result not split into high and low registers");
   result_hold_a: assert property (!done && !res_wr |=> $stable(threshold))
      else $error("result changed outside conversion end");
   cmp_keep_a: assert property (done && cmp_mode && !res_wr |=> $stable(threshold))
      else $error("threshold overwritten in compare mode");
   start_sample_a: assert property (start |=> sample_hold && r.ctrl[CTRL_GO_BIT])
      else $error("start write did not begin sampling");
   done_flags_a: assert property (done && !cmp_mode |=> !r.ctrl[CTRL_GO_BIT] && r.ctrl[CTRL_FLAG_BIT])
      else $error("conversion end did not clear go and set flag");
   no_restart_a: assert property (r.st == ST_IDLE && !start |=> r.st == ST_IDLE)
      else $error("sequence restarted without a start write");
   cmp_repeat_a: assert property (done && cmp_mode |=> sample_hold && r.ctrl[CTRL_GO_BIT])
      else $error("compare mode did not repeat");
   cmp_hit_a: assert property (done && cmp_mode && hit |=> conv_int_req == int_enable)
      else $error("threshold crossing did not raise the flag");
   flag_set_wins_a: assert property (done && ctrl_wr |=> r.ctrl[CTRL_FLAG_BIT] || cmp_mode)
      else $error("software clear beat a hardware flag set");
   abort_stop_a: assert property (abort |=> r.st == ST_IDLE ##1 r.st == ST_IDLE || start)
      else $error("clearing go did not abort the conversion");
   sample_clamp_a: assert property (start |=> r.cnt >= SAMPLE_MIN && r.cnt <= SAMPLE_MAX)
      else $error("sample length out of range");
   convert_len_a: assert property (sample_hold && tick && r.cnt == 4'h1 && !abort |=>
      convert_run && r.cnt == CONVERT_TADS)
      else $error("conversion phase not twelve clocks");
   disabled_start_a: assert property (ctrl_wr && !wr_data[CTRL_EN_BIT] |=> !r.ctrl[CTRL_GO_BIT] && !sample_hold)
      else $error("start accepted while disabled");
   res_write_a: assert property (wr_en && wr_idx == IDX_RES_HI && !done |=> r.res_hi == $past(wr_data))
      else $error("result register not writable");

   // register invariants
   fixed_bit_a: assert property ((r.ctrl & CTRL_FIXED_MASK) == CTRL_FIXED_MASK)
      else $error("control bit four does not read one");
   timing_gap_a: assert property ((r.timing & ~TIMING_WMASK) == 8'h00)
      else $error("timing bit four does not read zero");
   go_tracks_run_a: assert property (
      r.ctrl[CTRL_GO_BIT] == (r.st != ST_IDLE))
      else $error("start/done bit disagrees with the sequence");
   disabled_idle_a: assert property (
      !r.ctrl[CTRL_EN_BIT] |-> r.st == ST_IDLE)
      else $error("sequence running on a disabled converter");
   ctrl_hold_a: assert property (
      !ctrl_wr && !done |=> $stable(r.ctrl))
      else $error("control changed without a write or a conversion end");
   flag_clear_a: assert property (ctrl_wr && !wr_data[CTRL_FLAG_BIT] && !done |=>
      !r.ctrl[CTRL_FLAG_BIT])
      else $error("software could not clear the flag");
   single_end_a: assert property (
      done && !cmp_mode |=> r.st == ST_IDLE)
      else $error("single conversion did not return to idle");
   cmp_threshold_a: assert property (
      cmp_mode && !res_wr |=> $stable(threshold))
      else $error("threshold changed by hardware in compare mode");
   hit_flag_a: assert property (
      done && cmp_mode && hit |=> r.ctrl[CTRL_FLAG_BIT])
      else $error("threshold crossing left the flag clear");
   cmp_quiet_a: assert property (done && cmp_mode && !hit && !ctrl_wr |=>
      r.ctrl[CTRL_FLAG_BIT] == $past(r.ctrl[CTRL_FLAG_BIT]))
      else $error("flag set without a threshold crossing");
   abort_keep_a: assert property (abort |=> $stable(threshold))
      else $error("aborted conversion changed the result");

   // sequence counters and phase entries
   sample_wait_a: assert property (sample_hold && !tick && !abort |=>
      sample_hold && $stable(r.cnt))
      else $error("sample count moved between conversion clocks");
   sample_step_a: assert property (sample_hold && tick && r.cnt != 4'h1 && !abort |=>
      sample_hold && r.cnt == $past(r.cnt) - 4'h1)
      else $error("sample count did not step on a conversion clock");
   convert_wait_a: assert property (convert_run && !tick && !abort |=>
      convert_run && $stable(r.cnt))
      else $error("conversion count moved between conversion clocks");
   convert_step_a: assert property (convert_run && tick && r.cnt != 4'h1 && !abort |=>
      convert_run && r.cnt == $past(r.cnt) - 4'h1)
      else $error("conversion count did not step on a conversion clock");
   sample_entry_a: assert property ((!sample_hold ##1 sample_hold) |->
      $past(start) || $past(done && cmp_mode))
      else $error("sampling began without a start or a compare repeat");
   convert_entry_a: assert property ((!convert_run ##1 convert_run) |->
      $past(sample_hold && tick && r.cnt == 4'h1))
      else $error("conversion began before the sample time ran out");

   // register writes and reads
   timing_write_a: assert property (wr_en && wr_idx == IDX_TIMING |=>
      r.timing == ($past(wr_data) & TIMING_WMASK))
      else $error("timing register did not take the write");
   timing_hold_a: assert property (
      !(wr_en && wr_idx == IDX_TIMING) |=> $stable(r.timing))
      else $error("timing register changed without a write");
   pinsel_hold_a: assert property (
      !(wr_en && wr_idx == IDX_PINSEL) |=> $stable(pin_route_bits))
      else $error("pin routing changed without a write");
   res_lo_write_a: assert property (wr_en && wr_idx == IDX_RES_LO && !done |=>
      r.res_lo == $past(wr_data[1:0]))
      else $error("low result register not writable");
   low_read_a: assert property (rd_idx == IDX_RES_LO |-> rd_data[7:2] == 6'h00)
      else $error("low result register upper bits not zero");

   single_conv_c: cover property (start ##[1:900] done && !cmp_mode);
   cmp_hit_c: cover property (done && cmp_mode && hit);
   abort_c: cover property (abort && convert_run);
   disabled_c: cover property (ctrl_wr && wr_data[CTRL_GO_BIT] && !wr_data[CTRL_EN_BIT]);
   cmp_quiet_c: cover property (done && cmp_mode && !hit);
endmodule : adc_control

//--- adc_core_model.sv
// behavioural converter core facing the control block
// assumes one analog level from the bench for the selected input
`timescale 1ns/1ps
module adc_core_model (
   input logic aclk,
   input logic sample_hold,
   input logic convert_run,
   input adc_pkg::sel3_t input_selector,
   input adc_pkg::byte_t pin_route_bits,
   input adc_pkg::sample_t level,
   output adc_pkg::sample_t core_result
);
   import adc_pkg::*;
   sample_t held_r;
   sample_t junk_r = 10'h2aa;
   always @(posedge aclk) begin
      junk_r <= ~junk_r;
      // digital pins never reach the mux
      if (sample_hold) begin
         held_r <= pin_route_bits[input_selector] ? level : 10'h000;
      end
   end
   // code valid only while converting, garbage otherwise
   assign core_result = convert_run ? held_r : junk_r;
endmodule : adc_core_model

//--- sar_adc_control_compare_tb.sv
// self-checking bench for the converter control block
// assumes the core model drives core_result; axi4-lite master tasks
`timescale 1ns/1ps
module sar_adc_control_compare_tb;
   import adc_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, int_enable;
   addr_t awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic awready, wready, bvalid, arready, rvalid, conv_int_req, sample_hold, convert_run, conv_clk_tick;
   logic [1:0] bresp, rresp, r;
   byte_t pin_route_bits;
   sel3_t input_selector, s;
   sample_t core_result, level;
   int err_count, checks, sh_cnt, cr_cnt, tk_cnt, len, div;
   int divs[8] = '{2, 4, 6, 8, 12, 16, 24, 32};
   byte_t tt[8] = '{8'h00, 8'h2f, 8'h5f, 8'h60, 8'h83, 8'ha7, 8'hc4, 8'he1};

   adc_control dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .int_enable(int_enable), .conv_int_req(conv_int_req),
      .pin_route_bits(pin_route_bits), .input_selector(input_selector), .sample_hold(sample_hold),
      .convert_run(convert_run), .conv_clk_tick(conv_clk_tick), .core_result(core_result));
   adc_core_model core (.aclk(aclk), .sample_hold(sample_hold), .convert_run(convert_run),
      .input_selector(input_selector), .pin_route_bits(pin_route_bits), .level(level),
      .core_result(core_result));

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      sh_cnt += sample_hold;
      cr_cnt += convert_run;
      tk_cnt += conv_clk_tick;
   end

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task wrap_up();
      $display("errors %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : wrap_up

   task automatic axw(input reg_index_t i, input byte_t d, output logic [1:0] rs);
      int n;
      rs = 2'bxx;
      awaddr <= {i, 2'b00};
      wdata <= {24'h0, d};
      wstrb <= 4'h1;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            rs = bresp;
            break;
         end
      end
   endtask : axw

   task automatic wr(input reg_index_t i, input byte_t d);
      logic [1:0] rs;
      axw(i, d, rs);
      chk("bresp", {30'h0, rs}, {30'h0, RESP_OKAY});
   endtask : wr

   task automatic rdc(input string nm, input reg_index_t i, input byte_t e, input logic [1:0] er);
      int n;
      araddr <= {i, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            chk(nm, rdata, {24'h0, e});
            chk("rresp", {30'h0, rresp}, {30'h0, er});
            break;
         end
      end
      chk("read answered", {31'h0, n < 50}, 32'h1);
   endtask : rdc

   task automatic wait_idle();
      int n;
      logic seen;
      seen = 1'b0;
      for (n = 0; n < 3000; n++) begin
         @(posedge aclk);
         if (sample_hold || convert_run)
            seen = 1'b1;
         else if (seen)
            break;
      end
      chk("sequence finished", {31'h0, seen && n < 3000}, 32'h1);
   endtask : wait_idle

   task automatic idle_chk(input string nm);
      chk(nm, {31'h0, sample_hold | convert_run}, 32'h0);
   endtask : idle_chk

   initial begin
      #(40 * 20000);
      err_count++;
      wrap_up();
   end

   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, int_enable} = 6'h00;
      awaddr = 12'h000;
      araddr = 12'h000;
      wdata = 32'h0;
      wstrb = 4'h0;
      level = 10'h000;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rdc("ctrl reset", IDX_CTRL, 8'h10, RESP_OKAY);
      rdc("timing reset", IDX_TIMING, 8'h00, RESP_OKAY);
      rdc("pinsel reset", IDX_PINSEL, 8'h00, RESP_OKAY);
      rdc("res lo reset", IDX_RES_LO, 8'h00, RESP_OKAY);
      rdc("res hi reset", IDX_RES_HI, 8'h00, RESP_OKAY);
      rdc("unmapped read", 10'h098, 8'h00, RESP_SLVERR);
      axw(10'h098, 8'h5a, r);
      chk("unmapped write", {30'h0, r}, {30'h0, RESP_SLVERR});
      wr(IDX_PINSEL, 8'ha5);
      rdc("pinsel", IDX_PINSEL, 8'ha5, RESP_OKAY);
      chk("pins", pin_route_bits, 8'ha5);
      wr(IDX_PINSEL, 8'hff);
      wr(IDX_RES_HI, 8'h3c);
      wr(IDX_RES_LO, 8'hff);
      rdc("res hi rw", IDX_RES_HI, 8'h3c, RESP_OKAY);
      rdc("res lo rw", IDX_RES_LO, 8'h03, RESP_OKAY);
      // start on a disabled converter
      wr(IDX_CTRL, 8'h01);
      repeat (4) @(posedge aclk);
      idle_chk("disabled start");
      rdc("ctrl disabled", IDX_CTRL, 8'h10, RESP_OKAY);
      rdc("res kept", IDX_RES_HI, 8'h3c, RESP_OKAY);
      for (int k = 0; k < 8; k++) begin
         s = sel3_t'(3 * k + 1);
         level <= sample_t'(10'h2b7 + k * 10'h0c9);
         int_enable <= k[0];
         wr(IDX_TIMING, tt[k]);
         rdc("timing", IDX_TIMING, tt[k] & 8'hef, RESP_OKAY);
         len = tt[k][3:0] + 1;
         if (len < 2) len = 2;
         if (len > 15) len = 15;
         div = divs[tt[k][7:5]];
         sh_cnt = 0;
         cr_cnt = 0;
         tk_cnt = 0;
         wr(IDX_CTRL, 8'h81 | {4'h0, s, 1'b0});
         chk("selector", input_selector, s);
         wait_idle();
         rdc("ctrl done", IDX_CTRL, 8'hd0 | {4'h0, s, 1'b0}, RESP_OKAY);
         rdc("res hi", IDX_RES_HI, level[9:2], RESP_OKAY);
         rdc("res lo", IDX_RES_LO, {6'h0, level[1:0]}, RESP_OKAY);
         chk("int req", conv_int_req, k[0]);
         repeat (20) @(posedge aclk);
         chk("sample cycles", sh_cnt, len * div);
         chk("convert cycles", cr_cnt, 12 * div);
         chk("ticks", tk_cnt, len + 12);
      end
      // compare mode: threshold 0x100, equal then above
      wr(IDX_TIMING, 8'h00);
      wr(IDX_RES_HI, 8'h40);
      wr(IDX_RES_LO, 8'h00);
      level <= 10'h100;
      int_enable <= 1'b1;
      wr(IDX_CTRL, 8'h20);
      wr(IDX_CTRL, 8'ha0);
      wr(IDX_CTRL, 8'ha1);
      repeat (100) @(posedge aclk);
      rdc("cmp equal", IDX_CTRL, 8'hb1, RESP_OKAY);
      chk("int req quiet", conv_int_req, 1'b0);
      level <= 10'h101;
      repeat (100) @(posedge aclk);
      rdc("cmp above", IDX_CTRL, 8'hf1, RESP_OKAY);
      chk("int req cmp", conv_int_req, 1'b1);
      rdc("threshold hi", IDX_RES_HI, 8'h40, RESP_OKAY);
      rdc("threshold lo", IDX_RES_LO, 8'h00, RESP_OKAY);
      wr(IDX_CTRL, 8'ha0);
      repeat (3) @(posedge aclk);
      idle_chk("cmp stopped");
      rdc("ctrl cmp off", IDX_CTRL, 8'hb0, RESP_OKAY);
      // abort a single conversion while converting
      level <= 10'h3ff;
      wr(IDX_CTRL, 8'h81);
      repeat (8) @(posedge aclk);
      wr(IDX_CTRL, 8'h80);
      repeat (2) @(posedge aclk);
      idle_chk("aborted");
      rdc("ctrl aborted", IDX_CTRL, 8'h90, RESP_OKAY);
      rdc("res after abort", IDX_RES_HI, 8'h40, RESP_OKAY);
      wrap_up();
   end
endmodule : sar_adc_control_compare_tb
